// [rtl/tws_defines.vh]
// tws_defines.vh: offsets, field positions, reset values and counts for the
// three-wire synthesiser control core. Definitions only; included by bare name.
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// register offsets (byte addresses, one word each)
`define TWS_OFS_STATUS      8'h00
`define TWS_OFS_MASK        8'h04
`define TWS_OFS_CTRL        8'h08
`define TWS_OFS_DIVISOR     8'h0C
`define TWS_OFS_STATE       8'h10

// status / mask bit positions
`define TWS_EV_LOADED       0
`define TWS_EV_LOCK_GAIN    1
`define TWS_EV_LOCK_LOSS    2
`define TWS_EV_W            3

// control register
`define TWS_CTRL_PUMP_EN    0
`define TWS_CTRL_RESET      1'h1

// state register fields
`define TWS_ST_PORT_LSB     0
`define TWS_ST_MODE_LSB     4
`define TWS_ST_LOCK_BIT     6

// serial word layout
`define TWS_PORT_W          4
`define TWS_DIV_W_LONG      15
`define TWS_DIV_W_SHORT     14
`define TWS_WORD_W          19
`define TWS_BITCNT_W        5

// mode codes
`define TWS_MODE_0          2'h0
`define TWS_MODE_1          2'h1
`define TWS_MODE_2          2'h2
`define TWS_MODE_3          2'h3

// reference divider ratios
`define TWS_REF_RATIO_M32   11'h200
`define TWS_REF_RATIO_M1    11'h400
`define TWS_REF_RATIO_M0    11'h280
`define TWS_REF_CNT_W       11

// lock detector
`define TWS_LOCK_ERR_MAX    8'h04
`define TWS_LOCK_GOOD_CNT   4'h8

// reset values
`define TWS_DIVISOR_RESET   15'h0000
`define TWS_PORT_RESET      4'h0
`define TWS_MASK_RESET      3'h0

`endif

// [rtl/tws_pin_sync.v]
// tws_pin_sync.v: two-flop synchroniser for a group of pins, with edge flags.
// assumes pins are asynchronous to clk_sys; edges come from the second stage.
`timescale 1ns/1ps

module tws_pin_sync
#(
    parameter W = 1
)
(
    // clock and reset
    input  wire         clk_sys,
    input  wire         rst_n,
    // asynchronous pins
    input  wire [W-1:0] pin_in,
    // synchronised view
    output wire [W-1:0] level_out,
    output wire [W-1:0] rise_out,
    output wire [W-1:0] fall_out
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;
    reg [W-1:0] prev_reg;

    // only sync_reg reads meta_reg
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
            prev_reg <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~prev_reg;
    assign fall_out  = ~sync_reg & prev_reg;

endmodule // tws_pin_sync

// [rtl/tws_synth_ctrl.v]
// tws_synth_ctrl.v: digital core of a three-wire programmed PLL synthesiser:
// serial loader, programmable and reference dividers, phase/frequency
// comparator, lock detector, open-collector ports and a register port.
// assumes the serial bus, crystal and prescaler signals arrive as pins that are
// slow against clk_sys (40 MHz); the register master shares clk_sys.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "tws_defines.vh"

module tws_synth_ctrl
(
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // three-wire serial bus
    input  wire        ser_data,
    input  wire        ser_clk,
    input  wire        ser_en,
    // mode select, crystal reference and prescaled feedback
    input  wire [1:0]  mode_sel,
    input  wire        ref_osc_in,
    input  wire        divided_vco_feedback,
    // loop correction
    output reg         pump_up,
    output reg         pump_down,
    // lock pin, open drain
    output reg         lock_out,
    output reg         lock_oe,
    // general purpose open-collector ports
    output reg  [3:0]  general_purpose_port_outputs,
    output reg  [3:0]  general_purpose_port_oe,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // interrupt
    output reg         irq
);

    // divider ratio for the comparison frequency
    function [`TWS_REF_CNT_W-1:0] ref_ratio;
        input [1:0] mode;
        begin
            case (mode)
                `TWS_MODE_0: ref_ratio = `TWS_REF_RATIO_M0;
                `TWS_MODE_1: ref_ratio = `TWS_REF_RATIO_M1;
                default:     ref_ratio = `TWS_REF_RATIO_M32;
            endcase
        end
    endfunction

    // pin synchronisation
    wire [6:0] pin_level;
    wire [6:0] pin_rise;
    wire [6:0] pin_fall;

    tws_pin_sync #(.W(7)) u_sync
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .pin_in    ({mode_sel, divided_vco_feedback, ref_osc_in,
                     ser_en, ser_clk, ser_data}),
        .level_out (pin_level),
        .rise_out  (pin_rise),
        .fall_out  (pin_fall)
    );

    wire       data_lvl = pin_level[0];
    wire       clk_rise = pin_rise[1];
    wire       en_lvl   = pin_level[2];
    wire       en_fall  = pin_fall[2];
    wire       ref_rise = pin_rise[3];
    wire       fb_rise  = pin_rise[4];

    // mode code
    reg [1:0] mode_reg;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
            mode_reg <= `TWS_MODE_0;
        else
            mode_reg <= pin_level[6:5];
    end

    // serial loader
    reg [`TWS_WORD_W-1:0]     shift_reg;
    reg [`TWS_DIV_W_LONG-1:0] divisor_reg;
    reg [`TWS_PORT_W-1:0]     port_reg;
    reg                       loaded_pulse;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            shift_reg    <= {`TWS_WORD_W{1'b0}};
            divisor_reg  <= `TWS_DIVISOR_RESET;
            port_reg     <= `TWS_PORT_RESET;
            loaded_pulse <= 1'b0;
        end
        else
        begin
            loaded_pulse <= 1'b0;
            if (en_lvl && clk_rise)
                shift_reg <= {shift_reg[`TWS_WORD_W-2:0], data_lvl};
            if (en_fall)
            begin
                port_reg     <= shift_reg[`TWS_PORT_W-1:0];
                loaded_pulse <= 1'b1;
                if (mode_reg == `TWS_MODE_3)
                    divisor_reg <= {1'b0,
                        shift_reg[`TWS_DIV_W_SHORT+`TWS_PORT_W-1:`TWS_PORT_W]};
                else
                    divisor_reg <=
                        shift_reg[`TWS_DIV_W_LONG+`TWS_PORT_W-1:`TWS_PORT_W];
            end
        end
    end

    // programmable divider on the prescaled feedback
    reg [`TWS_DIV_W_LONG-1:0] fb_cnt_reg;
    reg                       fb_tick;
    wire [`TWS_DIV_W_LONG-1:0] fb_cnt_inc = fb_cnt_reg + 1'b1;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            fb_cnt_reg <= {`TWS_DIV_W_LONG{1'b0}};
            fb_tick    <= 1'b0;
        end
        else
        begin
            fb_tick <= 1'b0;
            if (fb_rise)
            begin
                // a divisor of zero or one ticks on every edge
                if (fb_cnt_inc >= divisor_reg)
                begin
                    fb_cnt_reg <= {`TWS_DIV_W_LONG{1'b0}};
                    fb_tick    <= 1'b1;
                end
                else
                    fb_cnt_reg <= fb_cnt_inc;
            end
        end
    end

    // reference divider
    reg [`TWS_REF_CNT_W-1:0] ref_cnt_reg;
    reg                      ref_tick;
    wire [`TWS_REF_CNT_W-1:0] ref_cnt_inc = ref_cnt_reg + 1'b1;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ref_cnt_reg <= {`TWS_REF_CNT_W{1'b0}};
            ref_tick    <= 1'b0;
        end
        else
        begin
            ref_tick <= 1'b0;
            if (ref_rise)
            begin
                // >= so a mode change never strands the count above the ratio
                if (ref_cnt_inc >= ref_ratio(mode_reg))
                begin
                    ref_cnt_reg <= {`TWS_REF_CNT_W{1'b0}};
                    ref_tick    <= 1'b1;
                end
                else
                    ref_cnt_reg <= ref_cnt_inc;
            end
        end
    end

    // phase/frequency comparator
    reg up_reg;
    reg dn_reg;
    reg pump_en_reg;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            up_reg    <= 1'b0;
            dn_reg    <= 1'b0;
            pump_up   <= 1'b0;
            pump_down <= 1'b0;
        end
        else
        begin
            if ((up_reg || ref_tick) && (dn_reg || fb_tick))
            begin
                up_reg <= 1'b0;
                dn_reg <= 1'b0;
            end
            else
            begin
                up_reg <= up_reg | ref_tick;
                dn_reg <= dn_reg | fb_tick;
            end
            pump_up   <= up_reg & pump_en_reg;
            pump_down <= dn_reg & pump_en_reg;
        end
    end

    // lock detector: count comparison periods with small phase error
    reg [7:0] err_cnt_reg;
    reg [3:0] good_cnt_reg;
    reg       locked_reg;
    reg       lock_gain_pulse;
    reg       lock_loss_pulse;
    wire      err_small = (err_cnt_reg <= `TWS_LOCK_ERR_MAX);

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            err_cnt_reg     <= 8'h00;
            good_cnt_reg    <= 4'h0;
            locked_reg      <= 1'b0;
            lock_gain_pulse <= 1'b0;
            lock_loss_pulse <= 1'b0;
        end
        else
        begin
            lock_gain_pulse <= 1'b0;
            lock_loss_pulse <= 1'b0;
            if (ref_tick)
                err_cnt_reg <= 8'h00;
            else if ((up_reg ^ dn_reg) && err_cnt_reg != 8'hFF)
                err_cnt_reg <= err_cnt_reg + 8'h01;
            if (ref_tick)
            begin
                if (!err_small)
                begin
                    good_cnt_reg <= 4'h0;
                    if (locked_reg)
                        lock_loss_pulse <= 1'b1;
                    locked_reg <= 1'b0;
                end
                else if (good_cnt_reg != `TWS_LOCK_GOOD_CNT)
                    good_cnt_reg <= good_cnt_reg + 4'h1;
                else if (!locked_reg)
                begin
                    locked_reg      <= 1'b1;
                    lock_gain_pulse <= 1'b1;
                end
            end
        end
    end

    // pins: open drain pulls low only; released means high impedance
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            lock_out                     <= 1'b0;
            lock_oe                      <= 1'b1;
            general_purpose_port_outputs <= 4'h0;
            general_purpose_port_oe      <= 4'h0;
        end
        else
        begin
            lock_out <= 1'b0;
            lock_oe <= ~locked_reg;
            general_purpose_port_outputs <= 4'h0;
            general_purpose_port_oe <= port_reg;
        end
    end

    // registers and interrupt
    reg [`TWS_EV_W-1:0] status_reg;
    reg [`TWS_EV_W-1:0] mask_reg;
    wire [`TWS_EV_W-1:0] ev_set = {lock_loss_pulse, lock_gain_pulse, loaded_pulse};
    wire wr_status = reg_wr && (reg_addr == `TWS_OFS_STATUS);

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            status_reg  <= {`TWS_EV_W{1'b0}};
            mask_reg    <= `TWS_MASK_RESET;
            pump_en_reg <= `TWS_CTRL_RESET;
            irq         <= 1'b0;
        end
        else
        begin
            // a new event wins over a simultaneous write-one clear
            if (wr_status)
                status_reg <= (status_reg & ~reg_wdata[`TWS_EV_W-1:0]) | ev_set;
            else
                status_reg <= status_reg | ev_set;
            if (reg_wr && reg_addr == `TWS_OFS_MASK)
                mask_reg <= reg_wdata[`TWS_EV_W-1:0];
            if (reg_wr && reg_addr == `TWS_OFS_CTRL)
                pump_en_reg <= reg_wdata[`TWS_CTRL_PUMP_EN];
            irq <= |(status_reg & mask_reg);
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TWS_OFS_STATUS:  reg_rdata <= {29'h0000_0000, status_reg};
                `TWS_OFS_MASK:    reg_rdata <= {29'h0000_0000, mask_reg};
                `TWS_OFS_CTRL:    reg_rdata <= {31'h0000_0000, pump_en_reg};
                `TWS_OFS_DIVISOR: reg_rdata <= {17'h0_0000, divisor_reg};
                `TWS_OFS_STATE:   reg_rdata <= {25'h000_0000, locked_reg,
                                                mode_reg, port_reg};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule // tws_synth_ctrl

// [tb/tws_synth_ctrl_properties.sv]
// tws_synth_ctrl_properties.sv: port checks for the synthesiser core.
// assumes binding to tws_synth_ctrl; enable and reference are raw pins.
`timescale 1ns/1ps

module tws_synth_ctrl_properties
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // watched pins
    input wire logic       ser_en,
    input wire logic       ref_osc_in,
    input wire logic       pump_up,
    input wire logic       pump_down,
    input wire logic       lock_out,
    input wire logic       lock_oe,
    input wire logic [3:0] general_purpose_port_outputs,
    input wire logic [3:0] general_purpose_port_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic        en_q;
    logic        ref_q;
    logic [3:0]  since_fall;
    logic [12:0] ref_cnt;
    // counters saturate so a stale edge never looks recent
    always @(posedge clk_sys)
    begin
        en_q  <= ser_en;
        ref_q <= ref_osc_in;
        if (!rst_n)
        begin
            since_fall <= 4'hf;
            ref_cnt    <= 13'h0000;
        end
        else
        begin
            if (en_q && !ser_en)
                since_fall <= 4'h0;
            else if (since_fall != 4'hf)
                since_fall <= since_fall + 4'h1;
            if (ref_osc_in && !ref_q && ref_cnt != 13'h1fff)
                ref_cnt <= ref_cnt + 13'h0001;
        end
    end
    property p_load_on_fall;
        $changed(general_purpose_port_oe) |-> since_fall <= 4'h8;
    endproperty
    a_load_on_fall: assert property (p_load_on_fall)
        else $error("ports moved away from an enable fall");
    property p_hold_in_frame;
        ser_en [*8] |-> $stable(general_purpose_port_oe);
    endproperty
    a_hold_in_frame: assert property (p_hold_in_frame)
        else $error("ports moved while enable high");
    property p_quiet_low;
        since_fall == 4'hf && !ser_en |-> $stable(general_purpose_port_oe);
    endproperty
    a_quiet_low: assert property (p_quiet_low)
        else $error("ports moved while enable low");
    property p_ports_low;
        general_purpose_port_outputs == 4'h0;
    endproperty
    a_ports_low: assert property (p_ports_low)
        else $error("port data not low");
    property p_lock_low;
        lock_out == 1'b0;
    endproperty
    a_lock_low: assert property (p_lock_low)
        else $error("lock data not low");
    property p_pump_excl;
        !(pump_up && pump_down);
    endproperty
    a_pump_excl: assert property (p_pump_excl)
        else $error("both pumps on");
    property p_lock_late;
        $fell(lock_oe) |-> ref_cnt >= 13'h1000;
    endproperty
    a_lock_late: assert property (p_lock_late)
        else $error("lock before enough reference edges");
    property p_reset_unlock;
        $rose(rst_n) |-> lock_oe && general_purpose_port_oe == 4'h0;
    endproperty
    a_reset_unlock: assert property (p_reset_unlock)
        else $error("wrong pin state after reset");
endmodule // tws_synth_ctrl_properties

// [tb/tws_host_model.sv]
// tws_host_model.sv: host on the three-wire bus.
// assumes a 200 ns link clock that stands low outside frames, except for the edges the stray task drives with enable low.
`timescale 1ns/1ps

module tws_host_model
(
    // three-wire bus
    output logic ser_data,
    output logic ser_clk,
    output logic ser_en
);
    initial
    begin
        ser_data = 1'b0;
        ser_clk  = 1'b0;
        ser_en   = 1'b0;
    end
    task send(input logic [23:0] w, input int n, input logic drop);
        ser_en = 1'b1;
        #100;
        for (int i = n - 1; i >= 0; i--)
        begin
            ser_data = w[i];
            #50 ser_clk = 1'b1;
            #100 ser_clk = 1'b0;
            #50;
        end
        if (drop)
            drop_en();
    endtask
    task drop_en();
        #100 ser_en = 1'b0;
        // data is meaningless now, so do not leave it looking valid
        #30 ser_data = ~ser_data;
    endtask
    // clock edges with enable low, on purpose
    task stray(input int n);
        repeat (n)
        begin
            ser_data = ~ser_data;
            #100 ser_clk = 1'b1;
            #100 ser_clk = 1'b0;
        end
    endtask
endmodule // tws_host_model

// [tb/tb_tws_synth_ctrl.sv]
// tb_tws_synth_ctrl.sv: self-checking bench for the synthesiser core.
// assumes the host model drives the serial pins; registers share clk_sys.
`timescale 1ns/1ps
`include "tws_defines.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end

module tb_tws_synth_ctrl;
    typedef struct packed {
        logic [1:0]  m;
        logic [23:0] w;
        logic [4:0]  n;
        logic [14:0] dv;
        logic [3:0]  p;
    } tws_row_t;
    tws_row_t    rows [6] = '{
        '{2'h0, 24'h05_a3c6, 5'h13, 15'h5a3c, 4'h6},
        '{2'h1, 24'h07_fff9, 5'h13, 15'h7fff, 4'h9},
        '{2'h2, 24'h00_0010, 5'h13, 15'h0001, 4'h0},
        '{2'h3, 24'h03_ffff, 5'h12, 15'h3fff, 4'hf},
        '{2'h3, 24'h07_fffa, 5'h13, 15'h3fff, 4'ha},
        '{2'h0, 24'hf8_0015, 5'h17, 15'h0001, 4'h5}};
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  mode_sel = 2'h0;
    logic        ref_osc_in = 1'b0;
    logic        divided_vco_feedback = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        run_ref = 1'b0;
    logic        fb_on = 1'b0;
    logic [1:0]  ref_div = 2'h0;
    logic        ser_data, ser_clk, ser_en, pump_up, pump_down, lock_out, lock_oe, irq;
    logic [3:0]  general_purpose_port_outputs, general_purpose_port_oe;
    logic [31:0] reg_rdata, d;
    int          bad_count = 0;
    int          samples_checked = 0;

    tws_synth_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ser_data(ser_data),
        .ser_clk(ser_clk), .ser_en(ser_en), .mode_sel(mode_sel), .ref_osc_in(ref_osc_in),
        .divided_vco_feedback(divided_vco_feedback), .pump_up(pump_up),
        .pump_down(pump_down), .lock_out(lock_out), .lock_oe(lock_oe),
        .general_purpose_port_outputs(general_purpose_port_outputs),
        .general_purpose_port_oe(general_purpose_port_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    tws_host_model host_u (.ser_data(ser_data), .ser_clk(ser_clk), .ser_en(ser_en));

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // reference and feedback start together so a locked loop sees no phase error
    always @(posedge clk_sys)
    begin
        ref_div <= (ref_div == 2'h2) ? 2'h0 : ref_div + 2'h1;
        if (run_ref && ref_div == 2'h2)
        begin
            ref_osc_in <= ~ref_osc_in;
            if (fb_on)
                divided_vco_feedback <= ~ref_osc_in;
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task wait_lock(input logic v, input int lim);
        int n;
        n = 0;
        while (lock_oe !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask
    task close_out();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
    initial
    begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(4);
        `CHK("lock_oe", 1'b1, lock_oe)
        rd(`TWS_OFS_CTRL, d);
        `CHK("ctrl", 32'h0000_0001, d)
        rd(8'hfc, d);
        `CHK("unmapped", 32'h0000_0000, d)
        $display("done: reset");
        foreach (rows[k])
        begin
            mode_sel <= rows[k].m;
            cyc(8);
            host_u.send(rows[k].w, rows[k].n, 1'b1);
            cyc(10);
            `CHK("port_oe", rows[k].p, general_purpose_port_oe)
            rd(`TWS_OFS_DIVISOR, d);
            `CHK("divisor", {17'h0_0000, rows[k].dv}, d)
            rd(`TWS_OFS_STATE, d);
            `CHK("state", {25'h000_0000, 1'b0, rows[k].m, rows[k].p}, d)
            wr(`TWS_OFS_STATUS, 32'h0000_0007);
        end
        $display("done: word table");
        host_u.stray(6);
        host_u.send(24'h00_0003, 4, 1'b1);
        cyc(10);
        rd(`TWS_OFS_DIVISOR, d);
        `CHK("stray", 32'h0000_0015, d)
        `CHK("port_oe", 4'h3, general_purpose_port_oe)
        $display("done: stray clocks");
        // the stray-clock frame left its load event pending; clear it before unmasking
        wr(`TWS_OFS_STATUS, 32'h0000_0001);
        wr(`TWS_OFS_MASK, 32'h0000_0001);
        host_u.send(24'h00_20a7, 19, 1'b0);
        cyc(10);
        `CHK("held", 4'h3, general_purpose_port_oe)
        `CHK("irq", 1'b0, irq)
        host_u.drop_en();
        cyc(10);
        `CHK("port_oe", 4'h7, general_purpose_port_oe)
        `CHK("irq", 1'b1, irq)
        wr(`TWS_OFS_STATUS, 32'h0000_0001);
        cyc(3);
        `CHK("irq", 1'b0, irq)
        wr(`TWS_OFS_MASK, 32'h0000_0000);
        host_u.send(24'h00_20a8, 19, 1'b1);
        cyc(10);
        `CHK("irq", 1'b0, irq)
        rd(`TWS_OFS_STATUS, d);
        `CHK("status", 32'h0000_0001, d)
        $display("done: load and interrupt");
        mode_sel <= `TWS_MODE_2;
        cyc(8);
        host_u.send(24'h00_2000, 19, 1'b1);
        cyc(10);
        run_ref <= 1'b1;
        fb_on <= 1'b1;
        wait_lock(1'b0, 40000);
        `CHK("lock_oe", 1'b0, lock_oe)
        rd(`TWS_OFS_STATE, d);
        `CHK("locked", 1'b1, d[6])
        fb_on <= 1'b0;
        wait_lock(1'b1, 8000);
        `CHK("lock_oe", 1'b1, lock_oe)
        `CHK("pumps", 2'b10, {pump_up, pump_down})
        rd(`TWS_OFS_STATUS, d);
        `CHK("status", 3'h7, d[2:0])
        $display("done: lock");
        // mid-run reset while the pump is driving up and a divisor is loaded
        rst_n <= 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        cyc(4);
        `CHK("rst_lock_oe", 1'b1, lock_oe)
        `CHK("rst_pumps", 2'b00, {pump_up, pump_down})
        rd(`TWS_OFS_DIVISOR, d);
        `CHK("rst_divisor", 32'h0000_0000, d)
        rd(`TWS_OFS_STATUS, d);
        `CHK("rst_status", 32'h0000_0000, d)
        $display("done: mid-run reset");
        close_out();
    end
endmodule // tb_tws_synth_ctrl

bind tws_synth_ctrl tws_synth_ctrl_properties chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .ser_en(ser_en), .ref_osc_in(ref_osc_in), .pump_up(pump_up), .pump_down(pump_down),
    .lock_out(lock_out), .lock_oe(lock_oe),
    .general_purpose_port_outputs(general_purpose_port_outputs),
    .general_purpose_port_oe(general_purpose_port_oe));
